// File: design/asc_pkg.sv
// Shared constants and types of the converter sequence control block
package asc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h30;
	localparam logic [7:0] IDX_RESULT_FIRST = 8'h31;
	localparam logic [7:0] IDX_RESULT_FOURTH = 8'h34;
	localparam logic [7:0] IDX_OPTIONS = 8'h39;

	// Control/status field positions
	localparam int unsigned CS_FLAG_BIT = 7;
	localparam int unsigned CS_ZERO_BIT = 6;
	localparam int unsigned CS_SCAN_BIT = 5;
	localparam int unsigned CS_MULTI_CHANNEL_BIT_BIT = 4;
	localparam int unsigned CS_CHAN_MSB = 3;

	// System options field positions
	localparam int unsigned OPT_POWER_BIT = 7;
	localparam int unsigned OPT_CLKSRC_BIT = 6;
	localparam int unsigned OPT_DELAY_BIT = 4;

	// Reset values
	localparam logic [5:0] CS_RESET = 6'h00;
	localparam logic OPT_POWER_RESET = 1'b0;
	localparam logic OPT_CLKSRC_RESET = 1'b0;
	localparam logic OPT_DELAY_RESET = 1'b1;

	// Timing counts, in converter clock cycles or bus clock cycles
	localparam int unsigned CONV_CYCLES = 32;
	localparam int unsigned SAMPLE_CYCLES = 12;
	localparam int unsigned SAR_BITS = 8;
	localparam int unsigned DELAY_WINDOW = 64;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_STORE
	} asc_state_e;

endpackage : asc_pkg

// File: design/asc_sync.sv
// Three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
module asc_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw input and filtered level
	input wire logic din,
	output logic dout
);

	logic meta_reg;
	logic stage2_reg;
	logic stage3_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RESET_VAL;
			stage2_reg <= RESET_VAL;
			stage3_reg <= RESET_VAL;
		end else begin
			meta_reg <= din;
			stage2_reg <= meta_reg;
			stage3_reg <= stage2_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= RESET_VAL;
		end else if (stage2_reg == stage3_reg) begin
			dout <= stage3_reg;
		end
	end

endmodule : asc_sync

// File: design/asc_sar.sv
// Successive approximation register, most significant bit first
`timescale 1ns/10ps
module asc_sar #(
	parameter int unsigned BITS = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Step control
	input wire logic clear,
	input wire logic trial_en,
	input wire logic decide_en,
	input wire logic [2:0] bit_sel,
	input wire logic comp_high,
	// Present approximation, also the DAC trial code
	output logic [BITS-1:0] approx
);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			approx <= '0;
		end else if (clear) begin
			approx <= '0;
		end else if (trial_en) begin
			approx[bit_sel] <= 1'b1;
		end else if (decide_en) begin
			// Input below trial level drops the bit
			approx[bit_sel] <= comp_high;
		end
	end

endmodule : asc_sar

// File: design/asc_top.sv
// Converter sequence control with AHB-Lite register access
`timescale 1ns/10ps
// How it works
// - Completion flag sets once the fourth result of a sequence is stored.
// - Result stores wait while a result read is being taken on the bus.
// - Single scan writes results one to four once, then halts.
// - Continuous scan never stops; fifth result overwrites the first.
// - Single channel mode converts the chosen channel into all four results.
// - Multi channel mode converts four channels, repeated each sequence.
// - Channel code drives the input multiplexer; reserved codes pass as is.
// - Multi channel result goes to register indexed by low channel bits.
// - Options bit 7 powers the converter; clear removes power.
// - Options bit 6 picks timing: bus clock at reset, RC oscillator when set.
// - Control bit 7 is read-only flag, bit 6 reads zero, rest read-write.
// - Any control write starts a new sequence and aborts the running one.
// - Stop-exit delay bit writable once in first 64 cycles, anytime special.
// - A sequence begins one clock after the control write.
// - Each conversion makes eight comparisons from the top bit, then stores.
// - Control write clears the flag; continuous mode keeps it set after.
// - Result registers are read-only; writes to them are ignored.
module asc_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Analog side and chip inputs
	input wire logic comparator_high,
	input wire logic rc_clock_pin,
	input wire logic special_mode,
	output logic converter_power_up,
	output logic converter_clock_source,
	output logic stop_exit_delay,
	output logic [3:0] analog_select,
	output logic sample_enable,
	output logic [7:0] dac_trial
);

	localparam int unsigned STEP_W = $clog2(asc_pkg::CONV_CYCLES);
	localparam logic [STEP_W-1:0] STEP_LAST =
		STEP_W'(asc_pkg::CONV_CYCLES - 1);
	localparam logic [STEP_W-1:0] STEP_SAMPLE_END =
		STEP_W'(asc_pkg::SAMPLE_CYCLES);
	localparam logic [STEP_W-1:0] STEP_COMPARE_END =
		STEP_W'(asc_pkg::SAMPLE_CYCLES + 2 * asc_pkg::SAR_BITS);
	localparam logic [6:0] DELAY_LIMIT = 7'(asc_pkg::DELAY_WINDOW);

	// Word index of a byte address
	function automatic logic [7:0] word_index(input logic [31:0] addr);
		word_index = addr[9:2];
	endfunction : word_index

	// True when the address selects one of the four result registers
	function automatic logic is_result(input logic [31:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		is_result = (addr[31:10] == 22'h00_0000) &&
			(idx >= asc_pkg::IDX_RESULT_FIRST) &&
			(idx <= asc_pkg::IDX_RESULT_FOURTH);
	endfunction : is_result

	// True when the address selects the given register index
	function automatic logic hits(input logic [31:0] addr,
		input logic [7:0] idx);
		hits = (addr[31:10] == 22'h00_0000) && (addr[9:2] == idx);
	endfunction : hits

	// Bus address phase capture
	logic take;
	logic rd_take;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;
	logic ctl_write;
	logic opt_write;

	// Register contents
	logic [5:0] ctl_reg;
	logic flag_reg;
	logic [7:0] result_reg [4];
	logic dly_written_reg;
	logic [6:0] boot_cnt_reg;

	// Sequencer
	asc_pkg::asc_state_e state_reg;
	logic [STEP_W-1:0] step_reg;
	logic [1:0] slot_reg;
	logic conv_tick;
	logic rc_level;
	logic rc_prev_reg;
	logic special_level;
	logic sar_clear;
	logic sar_trial;
	logic sar_decide;
	logic [2:0] sar_bit;
	logic [STEP_W-1:0] cmp_step;
	logic [7:0] sar_value;
	logic scan_on;
	logic multi_channel_bit_on;

	assign take = hsel && hready && (htrans == asc_pkg::HTRANS_NONSEQ);
	assign rd_take = take && !hwrite && is_result(haddr);
	assign ctl_write = wr_pend_reg && hits(wr_addr_reg, asc_pkg::IDX_CONTROL);
	assign opt_write = wr_pend_reg && hits(wr_addr_reg, asc_pkg::IDX_OPTIONS);
	assign scan_on = ctl_reg[asc_pkg::CS_SCAN_BIT];
	assign multi_channel_bit_on = ctl_reg[asc_pkg::CS_MULTI_CHANNEL_BIT_BIT];

	// Input synchronisers
	asc_sync #(
		.RESET_VAL(1'b0)
	) u_rc_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.din(rc_clock_pin),
		.dout(rc_level)
	);

	asc_sync #(
		.RESET_VAL(1'b0)
	) u_mode_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.din(special_mode),
		.dout(special_level)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_prev_reg <= 1'b0;
		end else begin
			rc_prev_reg <= rc_level;
		end
	end

	// Converter clock: every bus clock, or each rising RC edge
	assign conv_tick = converter_clock_source ?
		(rc_level && !rc_prev_reg) : 1'b1;

	// Write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h0000_0000;
		end else if (hready) begin
			wr_pend_reg <= take && hwrite;
			wr_addr_reg <= haddr;
		end
	end

	// Bus answer: zero wait state, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= asc_pkg::HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= asc_pkg::HRESP_OKAY;
		end
	end

	// Read data, captured at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= 32'h0000_0000;
			if (hits(haddr, asc_pkg::IDX_CONTROL)) begin
				hrdata[asc_pkg::CS_FLAG_BIT] <= flag_reg;
				hrdata[asc_pkg::CS_ZERO_BIT] <= 1'b0;
				hrdata[5:0] <= ctl_reg;
			end else if (hits(haddr, asc_pkg::IDX_OPTIONS)) begin
				hrdata[asc_pkg::OPT_POWER_BIT] <= converter_power_up;
				hrdata[asc_pkg::OPT_CLKSRC_BIT] <= converter_clock_source;
				hrdata[asc_pkg::OPT_DELAY_BIT] <= stop_exit_delay;
			end else if (is_result(haddr)) begin
				hrdata[7:0] <= result_reg[2'(word_index(haddr)
					- asc_pkg::IDX_RESULT_FIRST)];
			end
		end
	end

	// Control/status writable bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_reg <= asc_pkg::CS_RESET;
		end else if (ctl_write) begin
			ctl_reg <= hwdata[5:0];
		end
	end

	// System options: power and clock source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			converter_power_up <= asc_pkg::OPT_POWER_RESET;
			converter_clock_source <= asc_pkg::OPT_CLKSRC_RESET;
		end else if (opt_write) begin
			converter_power_up <= hwdata[asc_pkg::OPT_POWER_BIT];
			converter_clock_source <= hwdata[asc_pkg::OPT_CLKSRC_BIT];
		end
	end

	// Cycle count after reset for the delay bit window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_cnt_reg <= 7'h00;
		end else if (boot_cnt_reg < DELAY_LIMIT) begin
			boot_cnt_reg <= boot_cnt_reg + 7'h01;
		end
	end

	// Stop-exit delay bit: once early in normal modes, freely in special
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_exit_delay <= asc_pkg::OPT_DELAY_RESET;
			dly_written_reg <= 1'b0;
		end else if (opt_write) begin
			if (special_level) begin
				stop_exit_delay <= hwdata[asc_pkg::OPT_DELAY_BIT];
			end else if (!dly_written_reg && boot_cnt_reg < DELAY_LIMIT) begin
				stop_exit_delay <= hwdata[asc_pkg::OPT_DELAY_BIT];
				dly_written_reg <= 1'b1;
			end
		end
	end

	// Sequencer state, conversion step and result slot
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= asc_pkg::ST_IDLE;
			step_reg <= '0;
			slot_reg <= 2'h0;
		end else if (ctl_write) begin
			state_reg <= asc_pkg::ST_CONVERT;
			step_reg <= '0;
			slot_reg <= 2'h0;
		end else begin
			case (state_reg)
				asc_pkg::ST_IDLE: begin
					step_reg <= '0;
				end
				asc_pkg::ST_CONVERT: begin
					if (converter_power_up && conv_tick) begin
						if (step_reg == STEP_LAST) begin
							state_reg <= asc_pkg::ST_STORE;
						end else begin
							step_reg <= step_reg + 1'b1;
						end
					end
				end
				asc_pkg::ST_STORE: begin
					if (!rd_take) begin
						step_reg <= '0;
						slot_reg <= slot_reg + 2'h1;
						if (slot_reg == 2'h3 && !scan_on) begin
							state_reg <= asc_pkg::ST_IDLE;
						end else begin
							state_reg <= asc_pkg::ST_CONVERT;
						end
					end
				end
				default: begin
					state_reg <= asc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Result storage, deferred while a result read is taken
	always_ff @(posedge hclk) begin
		if (state_reg == asc_pkg::ST_STORE && !rd_take && !ctl_write) begin
			result_reg[slot_reg] <= sar_value;
		end
	end

	// Completion flag: cleared by control write, set by fourth store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_reg <= 1'b0;
		end else if (ctl_write) begin
			flag_reg <= 1'b0;
		end else if (state_reg == asc_pkg::ST_STORE && !rd_take &&
			slot_reg == 2'h3) begin
			flag_reg <= 1'b1;
		end
	end

	// Multiplexer select, fixed at the start of each conversion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_select <= 4'h0;
		end else if (state_reg == asc_pkg::ST_CONVERT && step_reg == '0) begin
			if (multi_channel_bit_on) begin
				analog_select <= {ctl_reg[asc_pkg::CS_CHAN_MSB -: 2],
					slot_reg};
			end else begin
				analog_select <= ctl_reg[asc_pkg::CS_CHAN_MSB:0];
			end
		end
	end

	// Sampling switch enable during the first part of a conversion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_enable <= 1'b0;
		end else begin
			sample_enable <= !ctl_write && converter_power_up &&
				state_reg == asc_pkg::ST_CONVERT &&
				step_reg < STEP_SAMPLE_END;
		end
	end

	// Comparison steps: even step sets trial bit, odd step decides it
	assign cmp_step = step_reg - STEP_SAMPLE_END;
	assign sar_bit = 3'(asc_pkg::SAR_BITS - 1) - cmp_step[3:1];
	assign sar_clear = ctl_write ||
		(state_reg == asc_pkg::ST_CONVERT && step_reg == '0);
	assign sar_trial = state_reg == asc_pkg::ST_CONVERT &&
		converter_power_up && conv_tick &&
		step_reg >= STEP_SAMPLE_END && step_reg < STEP_COMPARE_END &&
		!cmp_step[0];
	assign sar_decide = state_reg == asc_pkg::ST_CONVERT &&
		converter_power_up && conv_tick &&
		step_reg >= STEP_SAMPLE_END && step_reg < STEP_COMPARE_END &&
		cmp_step[0];

	asc_sar #(
		.BITS(asc_pkg::SAR_BITS)
	) u_sar (
		.clk(hclk),
		.rst_n(hresetn),
		.clear(sar_clear),
		.trial_en(sar_trial),
		.decide_en(sar_decide),
		.bit_sel(sar_bit),
		.comp_high(comparator_high),
		.approx(sar_value)
	);

	// Trial code to the capacitor array, trial bit shown before its decision
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dac_trial <= 8'h00;
		end else if (sar_trial) begin
			dac_trial <= sar_value | (8'h01 << sar_bit);
		end else begin
			dac_trial <= sar_value;
		end
	end

endmodule : asc_top

// File: dv/asc_analog_model.sv
// Analog front end model: a fixed level per channel plus an offset
`timescale 1ns/10ps
module asc_analog_model (
	// Converter side
	input wire logic [3:0] analog_select,
	input wire logic [7:0] dac_trial,
	input wire logic [7:0] offs,
	// Comparator result
	output logic comparator_high
);
	// Level of channel n is n*16+5 plus offset, so results name channels
	assign comparator_high = ({analog_select, 4'h5} + offs) >= dac_trial;
endmodule : asc_analog_model

// File: dv/asc_top_sva.sv
// Port checker for the converter sequence control block
`timescale 1ns/10ps
module asc_sva (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Converter side
	input wire logic special_mode,
	input wire logic converter_power_up,
	input wire logic converter_clock_source,
	input wire logic stop_exit_delay,
	input wire logic [3:0] analog_select,
	input wire logic sample_enable
);
	logic tk;
	logic [6:0] boot_cnt;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	assign tk = hsel && hready && htrans == 2'h2;
	// Cycles since reset, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) boot_cnt <= 7'h00;
		else if (boot_cnt != 7'h7f) boot_cnt <= boot_cnt + 7'h01;
	end
	zero_wait_a: assert property (hreadyout && !hresp)
		else $error("bus stalled or not okay");
	upper_zero_a: assert property (tk && !hwrite |=> hrdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	ctrl_read_a: assert property (
		tk && !hwrite && haddr == 32'h0000_00c0 |=> !hrdata[6])
		else $error("control bit 6 reads one");
	unmapped_read_a: assert property (
		tk && !hwrite && haddr > 32'h0000_00e7 |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	conv_start_a: assert property (
		tk && hwrite && haddr == 32'h0000_00c0 && converter_power_up
		|-> ##[2:3] sample_enable) else $error("sequence did not start");
	sample_len_a: assert property ($rose(sample_enable) |-> sample_enable[*8])
		else $error("sampling too short");
	sel_stable_a: assert property (
		sample_enable && $past(sample_enable) |-> $stable(analog_select))
		else $error("channel changed while sampling");
	opt_write_a: assert property (
		tk && hwrite && haddr == 32'h0000_00e4 ##1 1 |=>
		converter_power_up == $past(hwdata[7]) &&
		converter_clock_source == $past(hwdata[6]))
		else $error("options pins do not follow write");
	delay_lock_a: assert property (
		!special_mode && boot_cnt > 7'h48 |-> $stable(stop_exit_delay))
		else $error("delay bit changed late");
	cover property (tk && hwrite && haddr == 32'h0000_00c0);
	cover property ($rose(sample_enable));
	cover property (tk && !hwrite && haddr == 32'h0000_00c4);
endmodule : asc_sva

bind asc_top asc_sva i_asc_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.special_mode(special_mode), .converter_power_up(converter_power_up),
	.converter_clock_source(converter_clock_source),
	.stop_exit_delay(stop_exit_delay), .analog_select(analog_select),
	.sample_enable(sample_enable));

// File: dv/asc_top_tb.sv
// Register level testbench of the converter sequence control block
`timescale 1ns/10ps
module asc_top_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic special_mode = 1'b0;
	logic rc_clock_pin = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] offs = 8'h00;
	logic [1:0] rc_div = 2'h0;
	logic hready, hreadyout, hresp, comparator_high, pwr, csrc, dly, samp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [3:0] asel;
	logic [7:0] trial;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #20 hclk = ~hclk;
	assign hready = hreadyout;
	// Free running RC oscillator, one period every four bus clocks
	always @(posedge hclk) begin
		rc_div <= rc_div + 2'h1;
		rc_clock_pin <= rc_div[1];
	end
	asc_top i_asc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .comparator_high(comparator_high),
		.rc_clock_pin(rc_clock_pin), .special_mode(special_mode),
		.converter_power_up(pwr), .converter_clock_source(csrc),
		.stop_exit_delay(dly), .analog_select(asel), .sample_enable(samp),
		.dac_trial(trial));
	asc_analog_model i_asc_analog_model (.analog_select(asel),
		.dac_trial(trial), .offs(offs), .comparator_high(comparator_high));
	task test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end
	task check8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8
	// One single AHB-Lite transfer; read data lands in rd
	task xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task rd_chk(input logic [31:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		check8(rd[7:0], exp);
	endtask : rd_chk
	task wait_flag;
		rd = 32'h0000_0000;
		for (int k = 0; k < 300 && rd[7] !== 1'b1; k++)
			xfer(1'b0, 32'h0000_00c0, 8'h00);
	endtask : wait_flag
	// Results of one sequence for channel code c and model offset o
	task res_chk(input logic [3:0] c, input logic multi_channel_bit, input logic [7:0] o);
		for (int j = 0; j < 4; j++) begin
			rd_chk(32'h0000_00c4 + 4 * j,
				{multi_channel_bit ? {c[3:2], j[1:0]} : c, 4'h5} + o);
		end
	endtask : res_chk
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(32'h0000_00c0, 8'h00);
		rd_chk(32'h0000_00e4, 8'h10);
		xfer(1'b1, 32'h0000_00e4, 8'hc0);
		#1 check8({7'h00, csrc}, 8'h01);
		xfer(1'b1, 32'h0000_00e4, 8'h90);
		rd_chk(32'h0000_00e4, 8'h80);
		#1 check8({pwr, dly, 6'h00}, 8'h80);
		repeat (2500) @(posedge hclk);
		xfer(1'b1, 32'h0000_00e4, 8'h90);
		rd_chk(32'h0000_00e4, 8'h80);
		special_mode <= 1'b1;
		repeat (8) @(posedge hclk);
		xfer(1'b1, 32'h0000_00e4, 8'h90);
		rd_chk(32'h0000_00e4, 8'h90);
		special_mode <= 1'b0;
		rd_chk(32'h0000_00f0, 8'h00);
		xfer(1'b1, 32'h0000_00c0, 8'h45);
		rd_chk(32'h0000_00c0, 8'h05);
		wait_flag();
		check8(rd[7:0], 8'h85);
		res_chk(4'h5, 1'b0, 8'h00);
		xfer(1'b1, 32'h0000_00c4, 8'h00);
		repeat (200) @(posedge hclk);
		rd_chk(32'h0000_00c4, 8'h55);
		rd_chk(32'h0000_00c0, 8'h85);
		xfer(1'b1, 32'h0000_00e4, 8'hd0);
		xfer(1'b1, 32'h0000_00c0, 8'h07);
		repeat (200) @(posedge hclk);
		rd_chk(32'h0000_00c0, 8'h07);
		wait_flag();
		res_chk(4'h7, 1'b0, 8'h00);
		xfer(1'b1, 32'h0000_00e4, 8'h90);
		xfer(1'b1, 32'h0000_00c0, 8'h05);
		repeat (50) @(posedge hclk);
		xfer(1'b1, 32'h0000_00c0, 8'h12);
		rd_chk(32'h0000_00c0, 8'h12);
		wait_flag();
		res_chk(4'h2, 1'b1, 8'h00);
		for (int n = 1; n < 4; n++) begin
			xfer(1'b1, 32'h0000_00c0, {4'h1, 4'(4 * n)});
			wait_flag();
			res_chk(4'(4 * n), 1'b1, 8'h00);
		end
		xfer(1'b1, 32'h0000_00c0, 8'h36);
		wait_flag();
		res_chk(4'h6, 1'b1, 8'h00);
		offs <= 8'h02;
		repeat (200) @(posedge hclk);
		rd_chk(32'h0000_00c0, 8'hb6);
		res_chk(4'h6, 1'b1, 8'h02);
		test_done();
	end
endmodule : asc_top_tb
